/* include/parport_share_pkg.sv */
/*
  Constants for the parallel port FIFO service and floppy share block.
  Assumes a 32-bit APB register bus; every register index maps to byte address index*4.
*/
package parport_share_pkg;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned LVL_W      = 4;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned NPIN       = 22;

  // Register indices
  localparam logic [7:0] IDX_CTRL  = 8'h00;
  localparam logic [7:0] IDX_DATA  = 8'h01;
  localparam logic [7:0] IDX_PCTL  = 8'h02;
  localparam logic [7:0] IDX_PSTAT = 8'h03;
  localparam logic [7:0] IDX_FIFO  = 8'h04;
  localparam logic [7:0] IDX_LEVEL = 8'h05;
  localparam logic [7:0] IDX_MODE  = 8'hF1;

  // Block control register fields
  localparam int unsigned CTRL_MASK   = 0;
  localparam int unsigned CTRL_DMA    = 1;
  localparam int unsigned CTRL_DIR    = 2;
  localparam int unsigned CTRL_ECP    = 3;
  localparam int unsigned CTRL_PWR    = 4;
  localparam int unsigned CTRL_LVL    = 8;
  localparam logic [11:0] CTRL_RESET  = 12'h001;

  // Mode register fields
  localparam int unsigned MODE_SINGLE = 0;
  localparam int unsigned MODE_DUAL   = 1;

  // Port control register bits and pin vector order
  localparam int unsigned P_STB  = 0;
  localparam int unsigned P_ALF  = 1;
  localparam int unsigned P_INIT = 2;
  localparam int unsigned P_SLIN = 3;
  localparam int unsigned P_PDIR = 5;
  localparam logic [7:0]  PCTL_NO_CABLE = 8'h04;

  // Port status register: pin vector order and register bit positions
  localparam int unsigned S_ACK  = 0;
  localparam int unsigned S_BUSY = 1;
  localparam int unsigned S_PE   = 2;
  localparam int unsigned S_SLCT = 3;
  localparam int unsigned S_ERR  = 4;
  localparam int unsigned PSTAT_LSB = 3;
  localparam logic [7:0]  PSTAT_NO_CABLE = 8'h88;

  // Floppy core output vector order
  localparam int unsigned F_WDATA = 0;
  localparam int unsigned F_DEN   = 1;
  localparam int unsigned F_HSEL  = 2;
  localparam int unsigned F_WGATE = 3;
  localparam int unsigned F_DIR   = 4;
  localparam int unsigned F_STEP  = 5;
  localparam int unsigned F_DS0   = 6;
  localparam int unsigned F_DS1   = 7;
  localparam int unsigned F_MTR0  = 8;
  localparam int unsigned F_MTR1  = 9;

  // Pin positions inside the synchronised input vector
  localparam int unsigned PIN_PD   = 0;
  localparam int unsigned PIN_CTL  = 8;
  localparam int unsigned PIN_STAT = 12;
  localparam int unsigned PIN_FDD  = 17;
  localparam int unsigned PD_MTR0  = 6;

  typedef enum logic [1:0] {SHARE_OFF, SHARE_SINGLE, SHARE_DUAL} share_t;

  function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
    reg_addr = {2'b00, idx, 2'b00};
  endfunction : reg_addr
endpackage : parport_share_pkg

/* hw/parport_share.sv */
/*
  Parallel port FIFO service request and floppy-on-connector pin sharing, with APB registers.
  Assumes pin inputs are asynchronous, floppy core and FIFO peer signals share clock.
*/
// The implementer's own choice: the APB slave port.
// Functional notes
// - Reverse, mask and DMA clear: interrupt while FIFO holds at least sixteen minus threshold bytes.
// - Forward, mask and DMA clear: interrupt while FIFO holds at most threshold bytes.
// - Mode register selects single-drive (drive 1) or dual-drive (drives 0, 1) sharing.
// - Parallel port function unavailable while any sharing mode is selected.
// - Sharing: DMA ack ignored, interrupt inactive, DMA request low only ECP with DMA.
// - Sharing: data register reads back last written value.
// - Sharing: control reads strobe, autofeed, select-in 0 and init 1.
// - Sharing: status reads busy, paper-end, select 0 and ack, error 1.
// - Sharing routed by drive select: native floppy outputs tri-stated.
// - Sharing: PD0..PD4 feed index, track zero, write protect, read data, disk change.
// - Strobe and PD6 drive drive0 select and motor only in dual-drive mode.
// - Shared floppy signals work regardless of the port power bit.
// - Port on only with power bit set and sharing off.
// - Level field holds threshold minus one, threshold 1 to 16.
// - Threshold 16 behaves as threshold 15.
module parport_share
  import parport_share_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        pd_in,
  output logic      [7:0]        pd_out,
  output logic      [7:0]        pd_oe,
  input  wire logic [3:0]        ctl_in,
  output logic      [3:0]        ctl_out,
  output logic      [3:0]        ctl_oe,
  input  wire logic [4:0]        stat_in,
  output logic      [4:0]        stat_out,
  output logic      [4:0]        stat_oe,
  input  wire logic [4:0]        native_in_n,
  output logic      [9:0]        native_out,
  output logic                   native_oe,
  input  wire logic [9:0]        fdc_out,
  output logic      [4:0]        fdc_in_n,
  input  wire logic              fdc_port_drive_sel,
  output logic                   floppy_share_mode,
  input  wire logic              port_dma_ack_n,
  output logic                   port_dma_request,
  output logic                   port_dma_request_oe,
  output logic                   port_interrupt,
  output logic                   port_interrupt_oe,
  input  wire logic              periph_wr_valid,
  input  wire logic [7:0]        periph_wr_data,
  output logic                   periph_wr_ready,
  output logic                   periph_rd_valid,
  output logic      [7:0]        periph_rd_data,
  input  wire logic              periph_rd_ready
);

  if (DEPTH != (1 << LVL_W)) begin : g_bad_depth
    $error("parport_share: DEPTH must equal two to the level field width");
  end

  // Register state
  logic [11:0]      ctrl_q;
  logic [1:0]       mode_q;
  logic [7:0]       data_q;
  logic [7:0]       pctl_q;
  logic [31:0]      prdata_q;
  logic             pslverr_q;
  logic             irq_q;
  logic [NPIN-1:0]  pins_raw, filt_q;
  logic [7:0]       mem_q [DEPTH];
  logic [LVL_W-1:0] wptr_q, rptr_q;
  logic [CNT_W-1:0] count_q;

  // Decoded controls
  share_t            share;
  logic              sharing, port_on, dual, mask, dma_en, reverse, ecp;
  logic [LVL_W-1:0]  level;
  logic [CNT_W-1:0]  thr, thr_eff;
  logic              setup, access, wr_acc, rd_acc;
  logic              full, empty, host_push, host_pop, per_push, per_pop;
  logic              irq_d;
  logic [31:0]       rd_mux;
  logic              hit;

  function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    at = (a == reg_addr(idx));
  endfunction : at

  assign mask    = ctrl_q[CTRL_MASK];
  assign dma_en  = ctrl_q[CTRL_DMA];
  assign reverse = ctrl_q[CTRL_DIR];
  assign ecp     = ctrl_q[CTRL_ECP];
  assign level   = ctrl_q[CTRL_LVL +: LVL_W];

  always_comb begin
    if (mode_q[MODE_DUAL]) begin
      share = SHARE_DUAL;
    end else if (mode_q[MODE_SINGLE]) begin
      share = SHARE_SINGLE;
    end else begin
      share = SHARE_OFF;
    end
  end

  assign sharing           = (share != SHARE_OFF);
  assign dual              = (share == SHARE_DUAL);
  assign port_on           = !sharing && ctrl_q[CTRL_PWR];
  assign floppy_share_mode = sharing;

  // APB slave, zero wait states
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign wr_acc  = access && pwrite;
  assign rd_acc  = access && !pwrite;
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  assign hit = at(paddr, IDX_CTRL) || at(paddr, IDX_DATA) || at(paddr, IDX_PCTL) || at(paddr, IDX_PSTAT)
            || at(paddr, IDX_FIFO) || at(paddr, IDX_LEVEL) || at(paddr, IDX_MODE);

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (1'b1)
      at(paddr, IDX_CTRL):  rd_mux[11:0] = ctrl_q;
      at(paddr, IDX_MODE):  rd_mux[1:0]  = mode_q;
      at(paddr, IDX_DATA):  rd_mux[7:0]  = (sharing || !pctl_q[P_PDIR]) ? data_q
                                         : filt_q[PIN_PD +: 8];
      at(paddr, IDX_PCTL):  rd_mux[7:0]  = sharing ? PCTL_NO_CABLE : pctl_q;
      at(paddr, IDX_PSTAT): rd_mux[7:0]  = sharing ? PSTAT_NO_CABLE
                                         : {filt_q[PIN_STAT +: 5], 3'b000};
      at(paddr, IDX_FIFO):  rd_mux[7:0]  = mem_q[rptr_q];
      at(paddr, IDX_LEVEL): rd_mux[CNT_W+1:0] = {irq_q, sharing, count_q};
      default:              rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pslverr_q <= 1'b0;
    end else if (setup) begin
      pslverr_q <= !hit;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_acc && at(paddr, IDX_CTRL)) begin
      ctrl_q <= pwdata[11:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_q <= 2'b00;
    end else if (wr_acc && at(paddr, IDX_MODE)) begin
      mode_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_q <= 8'h00;
    end else if (wr_acc && at(paddr, IDX_DATA)) begin
      data_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pctl_q <= PCTL_NO_CABLE;
    end else if (wr_acc && at(paddr, IDX_PCTL)) begin
      pctl_q <= pwdata[7:0];
    end
  end

  // Three-stage input capture; a bit changes once stages two and three agree
  assign pins_raw = {native_in_n, stat_in, ctl_in, pd_in};

  for (genvar i = 0; i < NPIN; i++) begin : g_sync
    logic s1_q, s2_q, s3_q, f_q;

    always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        f_q  <= 1'b0;
      end else begin
        s1_q <= pins_raw[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          f_q <= s3_q;
        end
      end
    end

    assign filt_q[i] = f_q;
  end

  // Transfer FIFO: host writes forward, reads reverse; peer does the opposite
  assign full      = (count_q == CNT_W'(DEPTH));
  assign empty     = (count_q == '0);
  assign host_push = wr_acc && at(paddr, IDX_FIFO) && !reverse && !full && port_on;
  assign host_pop  = rd_acc && at(paddr, IDX_FIFO) && reverse && !empty && port_on;
  assign periph_wr_ready = port_on && reverse && !full;
  assign periph_rd_valid = port_on && !reverse && !empty;
  assign periph_rd_data  = mem_q[rptr_q];
  assign per_push  = periph_wr_valid && periph_wr_ready;
  assign per_pop   = periph_rd_valid && periph_rd_ready;

  always_ff @(posedge clock) begin
    if (host_push) begin
      mem_q[wptr_q] <= pwdata[7:0];
    end else if (per_push) begin
      mem_q[wptr_q] <= periph_wr_data;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wptr_q <= '0;
    end else if (!port_on) begin
      wptr_q <= '0;
    end else if (host_push || per_push) begin
      wptr_q <= wptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rptr_q <= '0;
    end else if (!port_on) begin
      rptr_q <= '0;
    end else if (host_pop || per_pop) begin
      rptr_q <= rptr_q + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (!port_on) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + CNT_W'(host_push || per_push) - CNT_W'(host_pop || per_pop);
    end
  end

  // Service request from the fill level
  assign thr     = CNT_W'(level) + 1'b1;
  assign thr_eff = (thr == CNT_W'(DEPTH)) ? CNT_W'(DEPTH - 1) : thr;

  always_comb begin
    irq_d = 1'b0;
    if (port_on && !mask && !dma_en) begin
      if (reverse) begin
        irq_d = (count_q >= CNT_W'(DEPTH) - thr_eff);
      end else begin
        irq_d = (count_q <= thr_eff);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // DMA request asks while data can move; acknowledge is ignored while sharing
  always_comb begin
    port_interrupt      = irq_q;
    port_interrupt_oe   = port_on;
    port_dma_request    = 1'b0;
    port_dma_request_oe = 1'b0;
    if (sharing) begin
      port_dma_request_oe = ecp && dma_en;
    end else if (port_on) begin
      port_dma_request_oe = 1'b1;
      port_dma_request    = dma_en && !mask && port_dma_ack_n && (reverse ? !empty : !full);
    end
  end

  // Native floppy pins give way once the connector carries the drive
  assign native_out = fdc_out;
  assign native_oe  = !(sharing && fdc_port_drive_sel);

  assign fdc_in_n = sharing ? filt_q[PIN_PD +: 5] : filt_q[PIN_FDD +: 5];

  // Connector pins
  always_comb begin
    pd_out   = 8'h00;
    pd_oe    = 8'h00;
    ctl_out  = 4'h0;
    ctl_oe   = 4'h0;
    stat_out = 5'h00;
    stat_oe  = 5'h00;
    if (sharing) begin
      stat_out[S_ACK]  = fdc_out[F_DS1];
      stat_out[S_BUSY] = fdc_out[F_MTR1];
      stat_out[S_PE]   = fdc_out[F_WDATA];
      stat_out[S_SLCT] = fdc_out[F_WGATE];
      stat_out[S_ERR]  = fdc_out[F_HSEL];
      stat_oe          = 5'h1F;
      ctl_out[P_ALF]   = fdc_out[F_DEN];
      ctl_out[P_INIT]  = fdc_out[F_DIR];
      ctl_out[P_SLIN]  = fdc_out[F_STEP];
      ctl_out[P_STB]   = fdc_out[F_DS0];
      ctl_oe           = {3'b111, dual};
      pd_out[PD_MTR0]  = fdc_out[F_MTR0];
      pd_oe[PD_MTR0]   = dual;
    end else if (port_on) begin
      pd_out  = data_q;
      pd_oe   = {8{!pctl_q[P_PDIR]}};
      ctl_out = pctl_q[3:0];
      ctl_oe  = 4'hF;
    end
  end

endmodule : parport_share

/* verif/parport_share_properties.sv */
/*
  Port assertions for the parport_share block.
  Assumes it is bound to the block with every port connected by name.
*/
module parport_share_properties
  import parport_share_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       floppy_share_mode,
  input wire logic       fdc_port_drive_sel,
  input wire logic       native_oe,
  input wire logic       port_interrupt_oe,
  input wire logic       port_dma_request,
  input wire logic       port_dma_request_oe,
  input wire logic [9:0] fdc_out,
  input wire logic [4:0] fdc_in_n,
  input wire logic [7:0] pd_in,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe,
  input wire logic [3:0] ctl_out,
  input wire logic [3:0] ctl_oe,
  input wire logic [4:0] stat_out,
  input wire logic [4:0] stat_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire logic sh = floppy_share_mode;
  // Drive lines held steady long enough to cross the synchroniser
  sequence pins_quiet;
    (sh && $stable(pd_in[4:0])) [*5];
  endsequence
  a_share_int_off: assert property (sh |-> !port_interrupt_oe)
    else $error("share irq enabled");
  a_share_dma_low: assert property (sh && port_dma_request_oe |-> !port_dma_request)
    else $error("share dma high");
  a_native_hiz: assert property (sh && fdc_port_drive_sel |-> !native_oe)
    else $error("native driven");
  a_stat_route: assert property (sh |-> stat_oe == 5'h1F && stat_out == {fdc_out[F_HSEL],
    fdc_out[F_WGATE], fdc_out[F_WDATA], fdc_out[F_MTR1], fdc_out[F_DS1]}) else $error("stat route");
  a_ctl_route: assert property (sh |-> ctl_oe[3:1] == 3'h7 &&
    ctl_out[3:1] == {fdc_out[F_STEP], fdc_out[F_DIR], fdc_out[F_DEN]}) else $error("ctl route");
  a_drive0_pair: assert property (sh && ctl_oe[0] |-> pd_oe[6] && ctl_out[0] == fdc_out[F_DS0]
    && pd_out[6] == fdc_out[F_MTR0]) else $error("drive0 route");
  a_pd_inputs: assert property (sh |-> pd_oe[4:0] == 5'h00)
    else $error("pd0-4 driven");
  a_pd_to_fdc: assert property (pins_quiet |-> fdc_in_n == pd_in[4:0])
    else $error("pd to fdc");
endmodule : parport_share_properties

/* verif/floppy_drive_model.sv */
/*
  Floppy drive on the parallel connector.
  Assumes the bench sets the drive status lines.
*/
module floppy_drive_model (
  input  wire logic [7:0] pd_out,
  input  wire logic [7:0] pd_oe,
  input  wire logic [3:0] ctl_out,
  input  wire logic [3:0] ctl_oe,
  input  wire logic [4:0] stat_out,
  input  wire logic [4:0] stat_oe,
  input  wire logic [4:0] drive_lines_n,
  output logic      [7:0] pd_in,
  output logic      [3:0] ctl_in,
  output logic      [4:0] stat_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines rest at the pull-up level, except PD0-PD4, which carry the drive status lines
  assign pd_in   = (pd_oe & pd_out) | (~pd_oe & {3'h7, drive_lines_n});
  assign ctl_in  = (ctl_oe & ctl_out) | ~ctl_oe;
  assign stat_in = (stat_oe & stat_out) | ~stat_oe;
endmodule : floppy_drive_model

/* verif/tb_top.sv */
/*
  Self-checking bench for parport_share.
  Assumes the drive model on the connector and an APB host.
*/
module tb_top
  import parport_share_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd;
  logic [7:0]        pd_in, pd_out, pd_oe, periph_wr_data, periph_rd_data;
  logic [3:0]        ctl_in, ctl_out, ctl_oe;
  logic [4:0]        stat_in, stat_out, stat_oe, native_in_n, fdc_in_n, drive_lines_n;
  logic [9:0]        native_out, fdc_out;
  logic              native_oe, fdc_port_drive_sel, floppy_share_mode, port_dma_ack_n, er;
  logic              port_dma_request, port_dma_request_oe, port_interrupt, port_interrupt_oe;
  logic              periph_wr_valid, periph_wr_ready, periph_rd_valid, periph_rd_ready;
  int                fails, checked;

  parport_share dut_u (.clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pd_in, .pd_out, .pd_oe, .ctl_in, .ctl_out, .ctl_oe, .stat_in, .stat_out, .stat_oe,
    .native_in_n, .native_out, .native_oe, .fdc_out, .fdc_in_n, .fdc_port_drive_sel,
    .floppy_share_mode, .port_dma_ack_n, .port_dma_request, .port_dma_request_oe, .port_interrupt,
    .port_interrupt_oe, .periph_wr_valid, .periph_wr_data, .periph_wr_ready, .periph_rd_valid,
    .periph_rd_data, .periph_rd_ready);
  floppy_drive_model drive_u (.pd_out, .pd_oe, .ctl_out, .ctl_oe, .stat_out, .stat_oe,
    .drive_lines_n, .pd_in, .ctl_in, .stat_in);

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s exp %h got %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk

  task automatic irq(input logic exp);
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, exp}, {31'h0, port_interrupt});
  endtask : irq

  task automatic push(input logic [7:0] d);
    periph_wr_valid <= 1'b1;
    periph_wr_data <= d;
    do @(posedge clock); while (periph_wr_ready !== 1'b1);
    periph_wr_valid <= 1'b0;
    @(posedge clock);
  endtask : push

  task automatic t_reset;
    rdchk("ctrl", IDX_CTRL, 32'h1);
    rdchk("pctl", IDX_PCTL, 32'h4);
    rdchk("mode", IDX_MODE, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("fdc_native", 32'h0A, {27'h0, fdc_in_n});
  endtask : t_reset

  task automatic t_share;
    apb(1'b1, IDX_DATA, 32'hA5);
    apb(1'b1, IDX_MODE, 32'h2);
    repeat (6) @(posedge clock);
    rdchk("data", IDX_DATA, 32'hA5);
    rdchk("pctl", IDX_PCTL, 32'h04);
    rdchk("pstat", IDX_PSTAT, 32'h88);
    rdchk("level", IDX_LEVEL, 32'h20);
    chk("native_oe", 32'h0, {31'h0, native_oe});
    chk("fdc_in", 32'h16, {27'h0, fdc_in_n});
    chk("dual_oe", 32'h3, {30'h0, ctl_oe[0], pd_oe[6]});
    chk("int_oe", 32'h0, {31'h0, port_interrupt_oe});
    apb(1'b1, IDX_MODE, 32'h1);
    fdc_out <= 10'h14A;
    drive_lines_n <= 5'h09;
    repeat (6) @(posedge clock);
    chk("single_oe", 32'h0, {30'h0, ctl_oe[0], pd_oe[6]});
    chk("fdc_in", 32'h09, {27'h0, fdc_in_n});
    chk("native_out", 32'h14A, {22'h0, native_out});
    fdc_port_drive_sel <= 1'b0;
    @(posedge clock);
    chk("native_oe_kept", 32'h1, {31'h0, native_oe});
    fdc_port_drive_sel <= 1'b1;
    apb(1'b1, IDX_CTRL, 32'h0A);
    chk("share_dma_oe", 32'h1, {31'h0, port_dma_request_oe});
    chk("share_dma", 32'h0, {31'h0, port_dma_request});
    apb(1'b1, IDX_CTRL, 32'h10);
    rdchk("level", IDX_LEVEL, 32'h20);
    apb(1'b1, IDX_MODE, 32'h0);
    repeat (2) @(posedge clock);
    rdchk("level", IDX_LEVEL, 32'h40);
  endtask : t_share

  task automatic t_rev;
    apb(1'b1, IDX_CTRL, 32'h0B14);
    for (int i = 0; i < 3; i++) push(8'(i));
    irq(1'b0);
    push(8'h03);
    irq(1'b1);
    for (int i = 0; i < 4; i++) rdchk("fifo", IDX_FIFO, 32'(i));
    irq(1'b0);
    apb(1'b1, IDX_CTRL, 32'h0F14);
    irq(1'b0);
    push(8'h55);
    irq(1'b1);
    apb(1'b1, IDX_CTRL, 32'h0F15);
    irq(1'b0);
  endtask : t_rev

  task automatic t_fwd;
    apb(1'b1, IDX_CTRL, 32'h0);
    apb(1'b1, IDX_CTRL, 32'h0310);
    irq(1'b1);
    for (int i = 0; i < 5; i++) apb(1'b1, IDX_FIFO, 32'h10 + 32'(i));
    irq(1'b0);
    periph_rd_ready <= 1'b1;
    do @(posedge clock); while (periph_rd_valid !== 1'b1);
    chk("pop", 32'h10, {24'h0, periph_rd_data});
    periph_rd_ready <= 1'b0;
    irq(1'b1);
    apb(1'b1, IDX_CTRL, 32'h0312);
    chk("dma_req", 32'h3, {30'h0, port_dma_request_oe, port_dma_request});
    irq(1'b0);
    apb(1'b1, IDX_PCTL, 32'h20);
    repeat (4) @(posedge clock);
    rdchk("pins", IDX_DATA, 32'hE9);
  endtask : t_fwd

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, periph_wr_valid, periph_rd_ready} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    periph_wr_data = 8'h00;
    native_in_n = 5'h0A;
    fdc_out = 10'h2B5;
    fdc_port_drive_sel = 1'b1;
    port_dma_ack_n = 1'b1;
    drive_lines_n = 5'h16;
    fails = 0;
    checked = 0;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_share;
    t_rev;
    t_fwd;
    stop_test;
  end

  initial begin
    repeat (5000) @(posedge clock);
    fails++;
    stop_test;
  end
endmodule : tb_top

bind parport_share parport_share_properties chk_u (.clock, .rst, .floppy_share_mode,
  .fdc_port_drive_sel, .native_oe, .port_interrupt_oe, .port_dma_request, .port_dma_request_oe,
  .fdc_out, .fdc_in_n, .pd_in, .pd_out, .pd_oe, .ctl_out, .ctl_oe, .stat_out, .stat_oe);
